// [rtl/afc_pkg.sv]
// afc_pkg: constants, field layout and types of the automatic rx flow control block.
// assumes a single 200 MHz clock and an apb slave at byte addresses.
package afc_pkg;

	// register map (byte addresses)
	localparam logic [7:0]  AFC_CONFIG_OFF   = 8'h0ac;
	localparam logic [7:0]  AFC_STAT_OFF     = 8'h0b4;
	localparam logic [31:0] AFC_CONFIG_RST   = 32'h0000_0000;
	localparam logic [31:0] AFC_CONFIG_WMASK = 32'h00ff_ffff;

	// config fields
	localparam int AFC_HIGH_MSB  = 23;
	localparam int AFC_HIGH_LSB  = 16;
	localparam int AFC_LOW_MSB   = 15;
	localparam int AFC_LOW_LSB   = 8;
	localparam int AFC_DUR_MSB   = 7;
	localparam int AFC_DUR_LSB   = 4;
	localparam int AFC_MCAST_BIT = 3;
	localparam int AFC_BCAST_BIT = 2;
	localparam int AFC_OWN_BIT   = 1;
	localparam int AFC_ANY_BIT   = 0;
	localparam int AFC_SEL_MSB   = 3;

	// status fields
	localparam int AFC_ST_PAUSED_BIT = 0;
	localparam int AFC_ST_REQ_BIT    = 1;
	localparam int AFC_ST_JAM_BIT    = 2;
	localparam int AFC_ST_HI_BIT     = 3;

	// fifo fill in bytes; watermarks count 64-byte units
	localparam int AFC_FIFO_W   = 15;
	localparam int AFC_UNIT_LSB = 6;
	localparam int AFC_PT_W     = 16;

	// timing
	localparam int AFC_CLK_MHZ       = 200;
	localparam int AFC_TICK_NS       = 100;
	localparam int AFC_TICK_CYC      = (AFC_TICK_NS * AFC_CLK_MHZ + 999) / 1000;
	localparam int AFC_TICK_W        = 5;
	localparam int AFC_DUR_W         = 13;
	localparam int AFC_DUR_SHORT_NS  = 5000;
	localparam int AFC_DUR_C3_NS     = 25000;
	localparam int AFC_DUR_LONG_NS   = 50000;
	localparam int AFC_SLOW_EXTRA_NS = 2200;
	localparam int AFC_CODE_C3       = 3;

	typedef enum logic [3:0] {
		AFC_IDLE        = 4'b0001,
		AFC_SEND_PAUSE  = 4'b0010,
		AFC_PAUSED      = 4'b0100,
		AFC_SEND_RESUME = 4'b1000
	} afc_state_t;

	typedef struct packed {
		afc_state_t            st;
		logic [31:0]           cfg;
		logic                  pready;
		logic                  pslverr;
		logic [31:0]           prdata;
		logic                  pause_req;
		logic                  pause_zero;
		logic [AFC_PT_W-1:0]   pause_time;
		logic                  jam;
		logic                  jam_start;
	} afc_regs_t;

	typedef struct packed {
		logic                  busy;
		logic [AFC_DUR_W-1:0]  remain;
		logic [AFC_TICK_W-1:0] tick;
	} afc_tmr_t;

	// jam length in 100 ns ticks; 10 Mb/s adds a fixed extra
	function automatic logic [AFC_DUR_W-1:0] afc_dur_ticks(input logic [3:0] code,
		input logic slow);
		int ns;
		if (int'(code) < AFC_CODE_C3)
			ns = (int'(code) + 1) * AFC_DUR_SHORT_NS;
		else if (int'(code) == AFC_CODE_C3)
			ns = AFC_DUR_C3_NS;
		else
			ns = (int'(code) - AFC_CODE_C3) * AFC_DUR_LONG_NS;
		if (slow)
			ns = ns + AFC_SLOW_EXTRA_NS;
		return AFC_DUR_W'(ns / AFC_TICK_NS);
	endfunction

endpackage

// [rtl/afc_jam_if.sv]
// afc_jam_if: start request and busy level between the flow controller and its jam timer.
// assumes both ends on the same clock.
`timescale 1ns/10ps
interface afc_jam_if;
	logic       start;
	logic [3:0] code;
	logic       slow;
	logic       busy;
	modport timer (input start, input code, input slow, output busy);
	modport ctrl  (output start, output code, output slow, input busy);
endinterface

// [rtl/afc_jam_timer.sv]
// afc_jam_timer: times one backpressure period from a duration code.
// assumes start is a one-cycle pulse that arrives only while busy is low.
`timescale 1ns/10ps
module afc_jam_timer
	import afc_pkg::*;
(
	input  wire logic  mclk,
	input  wire logic  srst,
	afc_jam_if.timer   jif
);
	afc_tmr_t r;
	afc_tmr_t next_r;

	always_comb
	begin
		next_r = r;
		if (!r.busy && jif.start)
		begin
			next_r.busy   = 1'b1;
			next_r.remain = afc_dur_ticks(jif.code, jif.slow);
			next_r.tick   = '0;
		end
		else if (r.busy)
		begin
			if (r.tick == AFC_TICK_W'(AFC_TICK_CYC - 1))
			begin
				next_r.tick   = '0;
				next_r.remain = r.remain - 1'b1;
				if (r.remain == AFC_DUR_W'(1))
					next_r.busy = 1'b0;
			end
			else
				next_r.tick = r.tick + 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			r <= '0;
		else
			r <= next_r;
	end

	assign jif.busy = r.busy;

	// helper: busy cycles against the expected length
	int unsigned cyc;
	int unsigned exp_cyc;
	always_ff @(posedge mclk)
	begin
		if (srst || (!r.busy && jif.start))
			cyc <= 0;
		else if (r.busy)
			cyc <= cyc + 1;
		if (!r.busy && jif.start)
			exp_cyc <= int'(afc_dur_ticks(jif.code, jif.slow)) * AFC_TICK_CYC;
	end

	property p_jam_len;
		@(posedge mclk) disable iff (srst)
		$fell(r.busy) |-> cyc == exp_cyc;
	endproperty
	a_jam_len: assert property (p_jam_len) else $error("jam period length wrong");

	property p_code0_fast;
		@(posedge mclk) disable iff (srst)
		(!r.busy && jif.start && jif.code == 4'h0 && !jif.slow) |=> r.remain == AFC_DUR_W'(50);
	endproperty
	a_code0_fast: assert property (p_code0_fast) else $error("code 0 load wrong");
endmodule

// [rtl/afc_top.sv]
// afc_top: automatic receive flow control with its apb configuration register.
// assumes mac-side inputs are on mclk; pause_ack pulses once a requested pause frame is sent.
`timescale 1ns/10ps
module afc_top
	import afc_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  srst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [AFC_FIFO_W-1:0] rx_fifo_bytes,
	input  wire logic                  full_duplex,
	input  wire logic                  speed_100,
	input  wire logic                  tx_enabled,
	input  wire logic                  rx_preamble,
	input  wire logic                  rx_addr_valid,
	input  wire logic                  rx_is_mcast,
	input  wire logic                  rx_is_bcast,
	input  wire logic                  rx_is_own,
	input  wire logic [AFC_PT_W-1:0]   pause_time_value,
	input  wire logic                  pause_ack,
	output logic                       pause_req,
	output logic [AFC_PT_W-1:0]        pause_time,
	output logic                       jam
);
	afc_regs_t r;
	afc_regs_t next_r;
	afc_jam_if jif ();

	afc_jam_timer u_timer (
		.mclk (mclk),
		.srst (srst),
		.jif  (jif)
	);

	logic [AFC_FIFO_W-AFC_UNIT_LSB-1:0] fill_units;
	logic [7:0]                         hi_mark;
	logic [7:0]                         lo_mark;
	logic                               hi_reached;
	logic                               below_lo;
	logic                               auto_en;
	logic                               react_any;
	logic                               fd_ok;
	logic                               hd_ok;
	logic                               sel_match;
	logic                               jam_trig;
	logic                               access;
	logic                               mapped;
	logic                               st_paused;

	always_comb
	begin
		fill_units = rx_fifo_bytes[AFC_FIFO_W-1:AFC_UNIT_LSB];
		hi_mark    = r.cfg[AFC_HIGH_MSB:AFC_HIGH_LSB];
		lo_mark    = r.cfg[AFC_LOW_MSB:AFC_LOW_LSB];
		hi_reached = fill_units >= {1'b0, hi_mark};
		below_lo   = fill_units < {1'b0, lo_mark};
		auto_en    = |r.cfg[AFC_SEL_MSB:AFC_ANY_BIT];
		react_any  = r.cfg[AFC_ANY_BIT];
		fd_ok      = full_duplex && tx_enabled;
		hd_ok      = !full_duplex && tx_enabled;
		sel_match  = (rx_is_mcast && r.cfg[AFC_MCAST_BIT])
			|| (rx_is_bcast && r.cfg[AFC_BCAST_BIT])
			|| (rx_is_own && r.cfg[AFC_OWN_BIT]);
		// any-frame mode does not wait for address decode
		jam_trig   = react_any ? rx_preamble : (rx_addr_valid && sel_match);
		access     = psel && penable && !r.pready;
		mapped     = (paddr == AFC_CONFIG_OFF) || (paddr == AFC_STAT_OFF);
		st_paused  = r.st == AFC_PAUSED;
	end

	always_comb
	begin
		next_r = r;

		// apb slave: answers one cycle after the access phase begins
		next_r.pready  = access;
		next_r.pslverr = access && !mapped;
		if (access && pwrite && paddr == AFC_CONFIG_OFF)
			next_r.cfg = pwdata & AFC_CONFIG_WMASK;
		if (access && !pwrite)
		begin
			if (paddr == AFC_CONFIG_OFF)
				next_r.prdata = r.cfg;
			else if (paddr == AFC_STAT_OFF)
			begin
				next_r.prdata = '0;
				next_r.prdata[AFC_ST_PAUSED_BIT] = (r.st == AFC_PAUSED)
					|| (r.st == AFC_SEND_RESUME);
				next_r.prdata[AFC_ST_REQ_BIT]    = r.pause_req;
				next_r.prdata[AFC_ST_JAM_BIT]    = r.jam;
				next_r.prdata[AFC_ST_HI_BIT]     = hi_reached;
			end
			else
				next_r.prdata = '0;
		end

		// pause frame sequencing; paused state is the sent-pause flag
		case (r.st)
			AFC_IDLE:
			begin
				if (fd_ok && react_any && hi_reached)
					next_r.st = AFC_SEND_PAUSE;
			end
			AFC_SEND_PAUSE:
			begin
				if (!tx_enabled)
					next_r.st = AFC_IDLE;
				else if (pause_ack && r.pause_req)
					next_r.st = AFC_PAUSED;
			end
			AFC_PAUSED:
			begin
				if (tx_enabled && auto_en && below_lo)
					next_r.st = AFC_SEND_RESUME;
			end
			AFC_SEND_RESUME:
			begin
				if (!tx_enabled)
					next_r.st = AFC_PAUSED;
				else if (pause_ack && r.pause_req)
					next_r.st = AFC_IDLE;
			end
			default:
				next_r.st = AFC_IDLE;
		endcase
		next_r.pause_req  = (next_r.st == AFC_SEND_PAUSE) || (next_r.st == AFC_SEND_RESUME);
		next_r.pause_zero = next_r.st == AFC_SEND_RESUME;
		next_r.pause_time = next_r.pause_zero ? '0 : pause_time_value;

		// half duplex backpressure
		next_r.jam_start = hd_ok && hi_reached && jam_trig && !jif.busy
			&& !r.jam_start;
		next_r.jam       = hd_ok && jif.busy;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			r     <= '0;
			r.st  <= AFC_IDLE;
			r.cfg <= AFC_CONFIG_RST;
		end
		else
			r <= next_r;
	end

	// duration is latched by the timer at start; later code writes affect the next jam only
	assign jif.start = r.jam_start;
	assign jif.code  = r.cfg[AFC_DUR_MSB:AFC_DUR_LSB];
	assign jif.slow  = !speed_100;

	assign prdata     = r.prdata;
	assign pready     = r.pready;
	assign pslverr    = r.pslverr;
	assign pause_req  = r.pause_req;
	assign pause_time = r.pause_time;
	assign jam        = r.jam;

	property p_hi_pause;
		@(posedge mclk) disable iff (srst)
		(r.st == AFC_IDLE && fd_ok && react_any && fill_units >= {1'b0, hi_mark})
			|=> pause_req && !r.pause_zero && pause_time == $past(pause_time_value);
	endproperty
	a_hi_pause: assert property (p_hi_pause) else $error("no pause at high mark");

	property p_single_pause;
		@(posedge mclk) disable iff (srst)
		(pause_ack && pause_req && !r.pause_zero) |=> (!pause_req || r.pause_zero)[*2];
	endproperty
	a_single_pause: assert property (p_single_pause) else $error("second pause");

	property p_jam_on;
		@(posedge mclk) disable iff (srst)
		(r.jam_start && hd_ok) ##1 hd_ok |=> jam;
	endproperty
	a_jam_on: assert property (p_jam_on) else $error("jam not asserted");

	property p_resume;
		@(posedge mclk) disable iff (srst)
		(r.st == AFC_PAUSED && tx_enabled && auto_en && below_lo)
			|=> pause_req && r.pause_zero && pause_time == '0;
	endproperty
	a_resume: assert property (p_resume) else $error("no zero pause below low mark");

	property p_zero_after_pause;
		@(posedge mclk) disable iff (srst)
		$rose(r.pause_zero) |-> $past(st_paused) && $past(auto_en);
	endproperty
	a_zero_after_pause: assert property (p_zero_after_pause) else $error("stray zero pause");

	property p_tx_off;
		@(posedge mclk) disable iff (srst)
		!tx_enabled |=> !pause_req && !jam;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("flow control with tx off");

	property p_mcast;
		@(posedge mclk) disable iff (srst)
		(rx_addr_valid && rx_is_mcast && r.cfg[AFC_MCAST_BIT] && !react_any && hd_ok
			&& hi_reached && !jif.busy && !r.jam_start) |=> r.jam_start;
	endproperty
	a_mcast: assert property (p_mcast) else $error("multicast not jammed");

	property p_bcast;
		@(posedge mclk) disable iff (srst)
		(rx_addr_valid && rx_is_bcast && r.cfg[AFC_BCAST_BIT] && !react_any && hd_ok
			&& hi_reached && !jif.busy && !r.jam_start) |=> r.jam_start;
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast not jammed");

	property p_own;
		@(posedge mclk) disable iff (srst)
		(rx_addr_valid && rx_is_own && r.cfg[AFC_OWN_BIT] && !react_any && hd_ok
			&& hi_reached && !jif.busy && !r.jam_start) |=> r.jam_start;
	endproperty
	a_own: assert property (p_own) else $error("own address not jammed");

	property p_any_preamble;
		@(posedge mclk) disable iff (srst)
		(react_any && !rx_preamble) |=> !r.jam_start;
	endproperty
	a_any_preamble: assert property (p_any_preamble) else $error("jam without preamble");

	property p_fd_no_jam;
		@(posedge mclk) disable iff (srst)
		full_duplex |=> !r.jam_start && !jam;
	endproperty
	a_fd_no_jam: assert property (p_fd_no_jam) else $error("jam in full duplex");

	property p_apb_answer;
		@(posedge mclk) disable iff (srst)
		(psel && penable && !pready) |=> pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");

	property p_cv_cycle;
		@(posedge mclk) disable iff (srst)
		(pause_req && !r.pause_zero) ##[1:1000] (pause_req && r.pause_zero);
	endproperty
	c_cv_cycle: cover property (p_cv_cycle);

	property p_cv_jam;
		@(posedge mclk) disable iff (srst)
		$rose(jam);
	endproperty
	c_cv_jam: cover property (p_cv_jam);

	property p_cv_cfg_wr;
		@(posedge mclk) disable iff (srst)
		access && pwrite && paddr == AFC_CONFIG_OFF;
	endproperty
	c_cv_cfg_wr: cover property (p_cv_cfg_wr);
endmodule

// [verification/afc_mac_model.sv]
// afc_mac_model: the mac transmit side that turns pause requests into pause frames.
// assumes mclk and a registered pause_req; ack_delay sets how slowly a frame goes out.
`timescale 1ns/10ps
module afc_mac_model
	import afc_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  srst,
	input  wire logic                  pause_req,
	input  wire logic [AFC_PT_W-1:0]   pause_time,
	input  wire logic [7:0]            ack_delay,
	output logic                       pause_ack,
	output int                         frames,
	output logic      [AFC_PT_W-1:0]   last_time
);
	int wait_cnt;

	// one frame per request; the ack edge itself is skipped so a held request is not sent twice
	always_ff @(posedge mclk)
	begin
		pause_ack <= 1'b0;
		if (srst)
		begin
			wait_cnt  <= 0;
			frames    <= 0;
			last_time <= '0;
		end
		else if (pause_req && !pause_ack)
		begin
			if (wait_cnt >= int'(ack_delay))
			begin
				pause_ack <= 1'b1;
				frames    <= frames + 1;
				last_time <= pause_time;
				wait_cnt  <= 0;
			end
			else
				wait_cnt <= wait_cnt + 1;
		end
		else
			wait_cnt <= 0;
	end
endmodule

// [verification/tb_top.sv]
// tb_top: self-checking bench for afc_top with an apb master and a mac model.
// assumes the 2-cycle apb access of the design and a 5 ns mclk.
`timescale 1ns/10ps
module tb_top;
	import afc_pkg::*;
	logic                  mclk, srst, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]            paddr, ack_delay;
	logic [31:0]           pwdata, prdata, rd;
	logic [AFC_FIFO_W-1:0] fill;
	logic                  full_duplex, speed_100, tx_enabled, rx_preamble, rx_addr_valid;
	logic                  rx_is_mcast, rx_is_bcast, rx_is_own, pause_ack, pause_req, jam;
	logic [AFC_PT_W-1:0]   ptv, pause_time, last_time;
	int                    frames, fail_count, compares;

	afc_top dut_u (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_fifo_bytes(fill), .full_duplex(full_duplex), .speed_100(speed_100),
		.tx_enabled(tx_enabled), .rx_preamble(rx_preamble), .rx_addr_valid(rx_addr_valid),
		.rx_is_mcast(rx_is_mcast), .rx_is_bcast(rx_is_bcast), .rx_is_own(rx_is_own),
		.pause_time_value(ptv), .pause_ack(pause_ack), .pause_req(pause_req),
		.pause_time(pause_time), .jam(jam));

	afc_mac_model mac_u (.mclk(mclk), .srst(srst), .pause_req(pause_req),
		.pause_time(pause_time), .ack_delay(ack_delay), .pause_ack(pause_ack),
		.frames(frames), .last_time(last_time));

	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		if (fail_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		check("apb pready", {31'h0, pready}, 32'h0000_0001);
	endtask

	task automatic wait_cycles(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic wait_req(input string what);
		int n;
		n = 0;
		while (pause_req !== 1'b1 && n < 20)
		begin
			@(posedge mclk);
			n++;
		end
		check(what, {31'h0, pause_req}, 32'h0000_0001);
	endtask

	task automatic t_regs();
		apb(0, AFC_CONFIG_OFF, 32'h0);
		check("cfg reset", rd, AFC_CONFIG_RST);
		apb(1, AFC_CONFIG_OFF, 32'hffff_ffff);
		apb(0, AFC_CONFIG_OFF, 32'h0);
		check("cfg fields", rd, 32'h00ff_ffff);
		apb(0, 8'h00, 32'h0);
		check("unmapped err", {31'h0, err}, 32'h0000_0001);
		check("unmapped data", rd, 32'h0000_0000);
		apb(1, AFC_CONFIG_OFF, 32'h0);
	endtask

	// high mark 4 units, low mark 2 units; the mac answers after dly cycles
	task automatic t_pause(input logic [7:0] dly, input logic [15:0] pt);
		int f0;
		ack_delay <= dly;
		ptv <= pt;
		full_duplex <= 1'b1;
		fill <= 15'h00ff;
		apb(1, AFC_CONFIG_OFF, 32'h0004_0201);
		f0 = frames;
		wait_cycles(10);
		check("pause below high", {31'h0, pause_req}, 32'h0000_0000);
		fill <= 15'h0100;
		wait_req("pause at high");
		check("pause time", {16'h0, pause_time}, {16'h0, pt});
		wait_cycles(int'(dly) + 40);
		check("single pause", frames, f0 + 1);
		apb(0, AFC_STAT_OFF, 32'h0);
		check("status sent", rd & 32'h0000_0009, 32'h0000_0009);
		fill <= 15'h0080;
		wait_cycles(20);
		check("no resume at low", frames, f0 + 1);
		fill <= 15'h007f;
		wait_req("resume below low");
		check("resume time", {16'h0, pause_time}, 32'h0000_0000);
		wait_cycles(int'(dly) + 10);
		check("resume sent", frames, f0 + 2);
		check("resume frame", {16'h0, last_time}, 32'h0000_0000);
		fill <= 15'h0000;
		// let the edge pass so a following scenario may drive fill again
		@(posedge mclk);
	endtask

	// class bits alone never pause in full duplex; transmitter off blocks everything
	task automatic t_quiet();
		int f0;
		f0 = frames;
		apb(1, AFC_CONFIG_OFF, 32'h0004_020e);
		fill <= 15'h0100;
		wait_cycles(30);
		fill <= 15'h0000;
		wait_cycles(30);
		check("full duplex classes", frames, f0);
		tx_enabled <= 1'b0;
		apb(1, AFC_CONFIG_OFF, 32'h0004_020f);
		fill <= 15'h0100;
		wait_cycles(30);
		check("tx off pause", frames, f0);
		full_duplex <= 1'b0;
		rx_preamble <= 1'b1;
		@(posedge mclk);
		rx_preamble <= 1'b0;
		wait_cycles(20);
		check("tx off jam", {31'h0, jam}, 32'h0000_0000);
		fill <= 15'h0000;
		wait_cycles(2);
		tx_enabled <= 1'b1;
	endtask

	// kind: 0 preamble, 1 multicast, 2 broadcast, 3 own address; exp in cycles, 0 for none
	task automatic t_jam(input logic [31:0] cfg, input int kind, input logic spd, input int exp);
		int n;
		int len;
		logic ok;
		full_duplex <= 1'b0;
		speed_100 <= spd;
		apb(1, AFC_CONFIG_OFF, cfg);
		fill <= 15'h0100;
		@(posedge mclk);
		rx_preamble <= (kind == 0);
		rx_addr_valid <= (kind != 0);
		rx_is_mcast <= (kind == 1);
		rx_is_bcast <= (kind == 2);
		rx_is_own <= (kind == 3);
		@(posedge mclk);
		rx_preamble <= 1'b0;
		rx_addr_valid <= 1'b0;
		n = 0;
		len = 0;
		while (jam !== 1'b1 && n < 10)
		begin
			@(posedge mclk);
			n++;
		end
		while (jam === 1'b1 && len < 20000)
		begin
			@(posedge mclk);
			len++;
		end
		// 25 cycles of slack, a little over one 100 ns tick; the timer restarts its tick at each start, so the trigger position does not change the length
		ok = (exp == 0) ? (len == 0) : (len + 25 > exp && len < exp + 25);
		check("jam length", {31'h0, ok}, 32'h0000_0001);
		fill <= 15'h0000;
		wait_cycles(5);
	endtask

	initial
	begin
		{srst, psel, penable, pwrite, rx_preamble, rx_addr_valid} = 6'b100000;
		{rx_is_mcast, rx_is_bcast, rx_is_own, full_duplex} = 4'b0000;
		{speed_100, tx_enabled} = 2'b11;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		fill = 15'h0000;
		ptv = 16'h0000;
		ack_delay = 8'h00;
		fail_count = 0;
		compares = 0;
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		t_regs();
		t_pause(8'h00, 16'h1234);
		t_pause(8'h14, 16'hffff);
		t_quiet();
		t_jam(32'h0004_0008, 1, 1'b1, 1000);
		t_jam(32'h0004_0004, 2, 1'b1, 1000);
		t_jam(32'h0004_0002, 3, 1'b1, 1000);
		t_jam(32'h0004_0008, 2, 1'b1, 0);
		t_jam(32'h0004_0001, 0, 1'b1, 1000);
		t_jam(32'h0004_0031, 0, 1'b0, 5440);
		t_jam(32'h0004_0041, 0, 1'b1, 10000);
		close_out();
	end

	// the whole run needs about 20000 cycles
	initial
	begin
		#300000;
		fail_count++;
		close_out();
	end
endmodule
